/* File: aurx_pkg.sv */
// Package with register map, field positions and carrier types of the serial receive/break block.
package aurx_pkg;

	// ==========================================================================
	// Register byte offsets
	localparam logic [7:0] AURX_OFS_RCV_STATUS = 8'h00;
	localparam logic [7:0] AURX_OFS_RCV_DATA = 8'h04;
	localparam logic [7:0] AURX_OFS_TX_STATUS = 8'h08;
	localparam logic [7:0] AURX_OFS_BAUD_CTRL = 8'h0C;
	localparam logic [7:0] AURX_OFS_DIV_HIGH = 8'h10;
	localparam logic [7:0] AURX_OFS_DIV_LOW = 8'h14;
	localparam logic [7:0] AURX_OFS_TX_BUF = 8'h18;
	localparam logic [7:0] AURX_OFS_FLAGS = 8'h1C;

	// ==========================================================================
	// Field positions
	localparam int AURX_RS_PORT_EN = 7;
	localparam int AURX_RS_NINE_EN = 6;
	localparam int AURX_RS_CONT_EN = 4;
	localparam int AURX_RS_ADDR_EN = 3;
	localparam int AURX_RS_FRAMING_ERROR_FLAG = 2;
	localparam int AURX_RS_OVERRUN_FLAG = 1;
	localparam int AURX_RS_NINTH = 0;
	localparam int AURX_TS_TX_EN = 5;
	localparam int AURX_TS_SYNC = 4;
	localparam int AURX_TS_BREAK = 3;
	localparam int AURX_TS_HSPEED = 2;
	localparam int AURX_TS_EMPTY = 1;
	localparam int AURX_BC_IDLE = 6;
	localparam int AURX_BC_DIV16 = 3;
	localparam int AURX_BC_WAKE = 1;
	localparam int AURX_FL_RCV_IE = 3;
	localparam int AURX_FL_TXE = 1;
	localparam int AURX_FL_RCV = 0;

	// ==========================================================================
	// Reset values and timing counts
	localparam logic [7:0] AURX_RST_REG = 8'h00;
	localparam logic [7:0] AURX_RST_TX_STATUS = 8'h02;
	localparam logic [7:0] AURX_RST_BAUD_CTRL = 8'h40;
	localparam logic [3:0] AURX_OVS_LAST = 4'hF;
	localparam logic [3:0] AURX_OVS_MID = 4'h7;
	localparam logic [3:0] AURX_BRK_ZEROS = 4'hC;
	localparam logic [1:0] AURX_PRE_X64 = 2'h3;

	// ==========================================================================
	// Carrier types
	typedef enum logic [1:0] {
		AURX_RX_IDLE = 2'b00,
		AURX_RX_START = 2'b01,
		AURX_RX_DATA = 2'b10,
		AURX_RX_STOP = 2'b11
	} aurx_rx_state_t;

	typedef enum logic [1:0] {
		AURX_TX_IDLE = 2'b00,
		AURX_TX_START = 2'b01,
		AURX_TX_DATA = 2'b10,
		AURX_TX_STOP = 2'b11
	} aurx_tx_state_t;

	typedef struct packed {
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} aurx_apb_req_t;

endpackage : aurx_pkg

/* File: aurx_top.sv */
// Asynchronous serial receiver with wake-up, break transmit and APB register slave.
`timescale 1ns/10ps
module aurx_top (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// APB slave
	input wire aurx_pkg::aurx_apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line and sleep
	input wire logic serial_in_line,
	input wire logic sleep_mode,
	output logic serial_out_line,
	// Interrupt and wake
	output logic receive_irq,
	output logic wake_request
);

	// ==========================================================================
	// Registers
	logic [7:0] rcv_status;
	logic [7:0] rcv_data;
	logic [7:0] tx_status;
	logic [7:0] baud_ctrl;
	logic [7:0] div_high;
	logic [7:0] div_low;
	logic [7:0] tx_buf;
	logic tx_buf_full;
	logic receive_flag;
	logic receive_interrupt_enable;
	logic wake_flag;

	// ==========================================================================
	// APB decode
	wire logic bus_acc = apb_req.psel & apb_req.penable;
	wire logic bus_wr = bus_acc & apb_req.pwrite;
	wire logic bus_rd = bus_acc & ~apb_req.pwrite;
	wire logic hit_rs = apb_req.paddr == aurx_pkg::AURX_OFS_RCV_STATUS;
	wire logic hit_rd = apb_req.paddr == aurx_pkg::AURX_OFS_RCV_DATA;
	wire logic hit_ts = apb_req.paddr == aurx_pkg::AURX_OFS_TX_STATUS;
	wire logic hit_bc = apb_req.paddr == aurx_pkg::AURX_OFS_BAUD_CTRL;
	wire logic hit_dh = apb_req.paddr == aurx_pkg::AURX_OFS_DIV_HIGH;
	wire logic hit_dl = apb_req.paddr == aurx_pkg::AURX_OFS_DIV_LOW;
	wire logic hit_tb = apb_req.paddr == aurx_pkg::AURX_OFS_TX_BUF;
	wire logic hit_fl = apb_req.paddr == aurx_pkg::AURX_OFS_FLAGS;
	wire logic hit_any = hit_rs | hit_rd | hit_ts | hit_bc | hit_dh | hit_dl | hit_tb | hit_fl;
	wire logic [7:0] wbyte = apb_req.pwdata[7:0];
	wire logic rd_data_evt = bus_rd & hit_rd & ~pready;
	wire logic tb_wr_evt = bus_wr & hit_tb & ~pready & ~tx_buf_full;
	wire logic [7:0] flags_rd = {4'h0, receive_interrupt_enable, 1'b0, ~tx_buf_full,
		receive_flag};
	wire logic [7:0] next_rd_byte = hit_rs ? rcv_status : hit_rd ? rcv_data :
		hit_ts ? tx_status : hit_bc ? baud_ctrl : hit_dh ? div_high :
		hit_dl ? div_low : hit_fl ? flags_rd : 8'h00;

	// ==========================================================================
	// Control bits
	wire logic port_en = rcv_status[aurx_pkg::AURX_RS_PORT_EN] &
		~tx_status[aurx_pkg::AURX_TS_SYNC];
	wire logic nine_en = rcv_status[aurx_pkg::AURX_RS_NINE_EN];
	wire logic cont_en = rcv_status[aurx_pkg::AURX_RS_CONT_EN];
	wire logic addr_en = rcv_status[aurx_pkg::AURX_RS_ADDR_EN];
	wire logic wake_en = baud_ctrl[aurx_pkg::AURX_BC_WAKE];
	wire logic tx_en = tx_status[aurx_pkg::AURX_TS_TX_EN];
	wire logic brk_req = tx_status[aurx_pkg::AURX_TS_BREAK];

	// ==========================================================================
	// Baud generator: one tick per x16 sample, x64 slowed by a prescaler.
	logic [15:0] brg_cnt;
	logic [1:0] brg_pre;
	wire logic x64_mode = ~tx_status[aurx_pkg::AURX_TS_HSPEED] &
		~baud_ctrl[aurx_pkg::AURX_BC_DIV16];
	wire logic [15:0] brg_top = baud_ctrl[aurx_pkg::AURX_BC_DIV16] ? {div_high, div_low} :
		{8'h00, div_low};
	wire logic brg_wrap = brg_cnt == 16'h0000;
	wire logic ovs_tick = brg_wrap & (~x64_mode | brg_pre == aurx_pkg::AURX_PRE_X64);
	always_ff @(posedge clock) begin
		if (sys_rst | ~port_en) begin
			brg_cnt <= 16'h0000;
			brg_pre <= 2'h0;
		end else begin
			brg_cnt <= brg_wrap ? brg_top : brg_cnt - 16'h0001;
			if (brg_wrap) begin
				brg_pre <= brg_pre + 2'h1;
			end
		end
	end

	// ==========================================================================
	// Receiver: x16 sampler feeds a bit-rate shifter.
	aurx_pkg::aurx_rx_state_t rx_state;
	logic [3:0] rx_ovs;
	logic [3:0] rx_bit;
	logic [8:0] rx_shift;
	logic line_q;
	wire logic rx_mid = ovs_tick & rx_ovs == aurx_pkg::AURX_OVS_MID;
	wire logic rx_fall = line_q & ~serial_in_line;
	wire logic rx_rise = ~line_q & serial_in_line;
	wire logic [3:0] rx_bits = nine_en ? 4'h9 : 4'h8;
	wire logic rx_done = rx_state == aurx_pkg::AURX_RX_STOP & rx_mid;
	wire logic [7:0] rx_low = nine_en ? rx_shift[7:0] : rx_shift[8:1];
	wire logic rx_ninth = nine_en & rx_shift[8];
	wire logic rx_keep = ~(nine_en & addr_en & ~rx_ninth);
	wire logic rx_store = rx_done & rx_keep;
	wire logic rx_framing_error_flag = rx_store & ~serial_in_line;
	wire logic rx_overrun_flag = rx_store & receive_flag;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			line_q <= 1'b1;
		end else begin
			line_q <= serial_in_line;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst | ~port_en | ~cont_en | wake_en) begin
			rx_state <= aurx_pkg::AURX_RX_IDLE;
			rx_ovs <= 4'h0;
			rx_bit <= 4'h0;
			rx_shift <= 9'h000;
		end else begin
			if (ovs_tick) begin
				rx_ovs <= rx_ovs + 4'h1;
			end
			unique case (rx_state)
				aurx_pkg::AURX_RX_IDLE: begin
					rx_ovs <= 4'h0;
					if (rx_fall) begin
						rx_state <= aurx_pkg::AURX_RX_START;
					end
				end
				aurx_pkg::AURX_RX_START: begin
					if (rx_mid) begin
						rx_state <= serial_in_line ? aurx_pkg::AURX_RX_IDLE : aurx_pkg::AURX_RX_DATA;
						rx_bit <= 4'h0;
					end
				end
				aurx_pkg::AURX_RX_DATA: begin
					if (rx_mid) begin
						rx_shift <= {serial_in_line, rx_shift[8:1]};
						rx_bit <= rx_bit + 4'h1;
						if (rx_bit + 4'h1 == rx_bits) begin
							rx_state <= aurx_pkg::AURX_RX_STOP;
						end
					end
				end
				aurx_pkg::AURX_RX_STOP: begin
					if (rx_mid) begin
						rx_state <= aurx_pkg::AURX_RX_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Wake detector: armed while wake enable is set, edge seen by sleep-safe logic.
	wire logic wake_evt = wake_en & ~wake_flag & rx_fall;
	wire logic wake_end = wake_en & wake_flag & rx_rise;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			wake_flag <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			wake_flag <= wake_evt | (wake_flag & wake_en & ~wake_end);
			wake_request <= wake_evt | (wake_request & sleep_mode);
		end
	end

	// ==========================================================================
	// Receive flag, data and interrupt.
	wire logic next_receive_flag = rx_store | wake_evt | (receive_flag & ~rd_data_evt);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			receive_flag <= 1'b0;
			rcv_data <= aurx_pkg::AURX_RST_REG;
			receive_irq <= 1'b0;
		end else begin
			receive_flag <= next_receive_flag;
			receive_irq <= next_receive_flag & receive_interrupt_enable;
			if (rx_store & ~receive_flag) begin
				rcv_data <= rx_low;
			end
		end
	end

	// ==========================================================================
	// Transmitter with break sequence.
	aurx_pkg::aurx_tx_state_t tx_state;
	logic [3:0] tx_ovs;
	logic [3:0] tx_bit;
	logic [7:0] tx_shift;
	logic tx_is_brk;
	wire logic tx_tick = ovs_tick & tx_ovs == aurx_pkg::AURX_OVS_LAST;
	wire logic tx_load = tx_state == aurx_pkg::AURX_TX_IDLE & tx_buf_full & tx_en & port_en;
	wire logic [3:0] tx_len = tx_is_brk ? aurx_pkg::AURX_BRK_ZEROS : 4'h8;
	wire logic brk_done = tx_state == aurx_pkg::AURX_TX_STOP & tx_tick & tx_is_brk;
	always_ff @(posedge clock) begin
		if (sys_rst | ~tx_en | ~port_en) begin
			tx_state <= aurx_pkg::AURX_TX_IDLE;
			tx_ovs <= 4'h0;
			tx_bit <= 4'h0;
			tx_shift <= 8'h00;
			tx_is_brk <= 1'b0;
			serial_out_line <= 1'b1;
		end else begin
			if (ovs_tick) begin
				tx_ovs <= tx_ovs + 4'h1;
			end
			unique case (tx_state)
				aurx_pkg::AURX_TX_IDLE: begin
					tx_ovs <= 4'h0;
					serial_out_line <= 1'b1;
					if (tx_load) begin
						tx_state <= aurx_pkg::AURX_TX_START;
						tx_is_brk <= brk_req;
						tx_shift <= brk_req ? 8'h00 : tx_buf;
						serial_out_line <= 1'b0;
					end
				end
				aurx_pkg::AURX_TX_START: begin
					if (tx_tick) begin
						tx_state <= aurx_pkg::AURX_TX_DATA;
						tx_bit <= 4'h0;
						serial_out_line <= tx_shift[0] & ~tx_is_brk;
					end
				end
				aurx_pkg::AURX_TX_DATA: begin
					if (tx_tick) begin
						tx_bit <= tx_bit + 4'h1;
						tx_shift <= {1'b0, tx_shift[7:1]};
						if (tx_bit + 4'h1 == tx_len) begin
							tx_state <= aurx_pkg::AURX_TX_STOP;
							serial_out_line <= 1'b1;
						end else begin
							serial_out_line <= tx_shift[1] & ~tx_is_brk;
						end
					end
				end
				aurx_pkg::AURX_TX_STOP: begin
					if (tx_tick) begin
						tx_state <= aurx_pkg::AURX_TX_IDLE;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Register writes.
	wire logic tx_busy = tx_state != aurx_pkg::AURX_TX_IDLE;
	wire logic [7:0] next_rs_ctrl = bus_wr & hit_rs & ~pready ? (wbyte & 8'hF8) :
		(rcv_status & 8'hF8);
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rcv_status <= aurx_pkg::AURX_RST_REG;
			tx_status <= aurx_pkg::AURX_RST_TX_STATUS;
			baud_ctrl <= aurx_pkg::AURX_RST_BAUD_CTRL;
			div_high <= aurx_pkg::AURX_RST_REG;
			div_low <= aurx_pkg::AURX_RST_REG;
			tx_buf <= aurx_pkg::AURX_RST_REG;
			tx_buf_full <= 1'b0;
			receive_interrupt_enable <= 1'b0;
		end else begin
			rcv_status[7:3] <= next_rs_ctrl[7:3];
			if (~next_rs_ctrl[aurx_pkg::AURX_RS_CONT_EN]) begin
				rcv_status[aurx_pkg::AURX_RS_FRAMING_ERROR_FLAG] <= 1'b0;
				rcv_status[aurx_pkg::AURX_RS_OVERRUN_FLAG] <= 1'b0;
			end else begin
				rcv_status[aurx_pkg::AURX_RS_FRAMING_ERROR_FLAG] <= rx_framing_error_flag | (rcv_status[2] & ~rx_store);
				rcv_status[aurx_pkg::AURX_RS_OVERRUN_FLAG] <= rx_overrun_flag | rcv_status[1];
			end
			if (rx_store & ~receive_flag) begin
				rcv_status[aurx_pkg::AURX_RS_NINTH] <= rx_ninth;
			end
			if (bus_wr & hit_ts & ~pready) begin
				tx_status <= {wbyte[7:2], ~tx_busy, wbyte[0]};
			end else begin
				tx_status[aurx_pkg::AURX_TS_EMPTY] <= ~tx_busy & ~tx_load;
				if (brk_done) begin
					tx_status[aurx_pkg::AURX_TS_BREAK] <= 1'b0;
				end
			end
			if (bus_wr & hit_bc & ~pready) begin
				baud_ctrl <= {1'b0, baud_ctrl[6], 2'b00, wbyte[3], 1'b0, wbyte[1], 1'b0};
			end else if (wake_end) begin
				baud_ctrl[aurx_pkg::AURX_BC_WAKE] <= 1'b0;
			end
			baud_ctrl[aurx_pkg::AURX_BC_IDLE] <= rx_state == aurx_pkg::AURX_RX_IDLE;
			if (bus_wr & hit_dh & ~pready) begin
				div_high <= wbyte;
			end
			if (bus_wr & hit_dl & ~pready) begin
				div_low <= wbyte;
			end
			if (tb_wr_evt) begin
				tx_buf <= wbyte;
			end
			tx_buf_full <= tb_wr_evt | (tx_buf_full & ~tx_load);
			if (bus_wr & hit_fl & ~pready) begin
				receive_interrupt_enable <= wbyte[aurx_pkg::AURX_FL_RCV_IE];
			end
		end
	end

	// ==========================================================================
	// APB answer: one wait state, so pready rises in the second access cycle.
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= bus_acc & ~pready;
			pslverr <= bus_acc & ~pready & ~hit_any;
			prdata <= {24'h000000, next_rd_byte};
		end
	end

endmodule : aurx_top

/* File: aurx_asserts.sv */
// Port checker for the serial receive and break block.
`timescale 1ns/10ps
module aurx_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register bus
	input wire aurx_pkg::aurx_apb_req_t apb_req,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Lines and events
	input wire logic serial_in_line,
	input wire logic sleep_mode,
	input wire logic serial_out_line,
	input wire logic receive_irq,
	input wire logic wake_request
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire access = apb_req.psel && apb_req.penable;
	// ====
	// Bus answer
	chk_ready_one_wait: assert property ($rose(access) |=> pready) else $error("pready late");
	chk_ready_single: assert property (pready |=> !pready) else $error("pready too long");
	chk_ready_in_access: assert property (pready |-> $past(access)) else $error("stray pready");
	chk_err_with_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
	chk_err_data_zero: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
	chk_byte_lane: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper data");
	// ====
	// Lines and events
	chk_reset_idle: assert property ($past(sys_rst) |-> serial_out_line && !receive_irq
		&& !wake_request) else $error("outputs not idle after reset");
	chk_wake_sleep_hold: assert property (sleep_mode && wake_request |=> wake_request)
		else $error("wake request dropped in sleep");
	cov_unmapped: cover property (pslverr);
	cov_wake: cover property ($rose(wake_request));
	cov_tx_frame: cover property ($fell(serial_out_line));
endmodule : aurx_asserts

bind aurx_top aurx_asserts u_aurx_asserts (.clock(clock), .sys_rst(sys_rst),
	.apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.serial_in_line(serial_in_line), .sleep_mode(sleep_mode),
	.serial_out_line(serial_out_line), .receive_irq(receive_irq), .wake_request(wake_request));

/* File: aurx_node.sv */
// Remote serial node model driving the receive line and sampling the transmit line.
`timescale 1ns/10ps
module aurx_node #(
	parameter int BIT_CLOCKS = 16
) (
	// Clock
	input wire logic clock,
	// Serial lines
	input wire logic serial_out_line,
	output logic serial_in_line
);
	initial serial_in_line = 1'b1;
	// A low stop bit makes a framing fault on purpose.
	task automatic send_char(input logic [8:0] d, input int nbits, input logic stop);
		@(posedge clock);
		serial_in_line <= 1'b0;
		repeat (BIT_CLOCKS) @(posedge clock);
		for (int i = 0; i < nbits; i++) begin
			serial_in_line <= d[i];
			repeat (BIT_CLOCKS) @(posedge clock);
		end
		serial_in_line <= stop;
		repeat (BIT_CLOCKS) @(posedge clock);
		serial_in_line <= 1'b1;
		repeat (2 * BIT_CLOCKS) @(posedge clock);
	endtask : send_char
	task automatic set_line(input logic v);
		@(posedge clock);
		serial_in_line <= v;
	endtask : set_line
	// Samples thirteen bit centres after a start bit; unknown when no frame comes.
	task automatic capture(output logic [12:0] bits);
		int n;
		bits = 'x;
		n = 0;
		while (serial_out_line && n < 4000) begin
			@(posedge clock);
			n++;
		end
		if (n < 4000) begin
			repeat (BIT_CLOCKS / 2) @(posedge clock);
			for (int i = 0; i < 13; i++) begin
				repeat (BIT_CLOCKS) @(posedge clock);
				bits[i] = serial_out_line;
			end
		end
	endtask : capture
endmodule : aurx_node

/* File: aurx_tb.sv */
// Self-checking testbench of the serial receive and break block.
`timescale 1ns/10ps
module aurx_tb;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic err;
	} aurx_tb_row_t;
	localparam logic [7:0] ST = aurx_pkg::AURX_OFS_RCV_STATUS;
	localparam logic [7:0] DT = aurx_pkg::AURX_OFS_RCV_DATA;
	localparam logic [7:0] TS = aurx_pkg::AURX_OFS_TX_STATUS;
	localparam logic [7:0] BC = aurx_pkg::AURX_OFS_BAUD_CTRL;
	localparam logic [7:0] TB = aurx_pkg::AURX_OFS_TX_BUF;
	localparam logic [7:0] FL = aurx_pkg::AURX_OFS_FLAGS;
	localparam aurx_tb_row_t ROWS [5] = '{'{aurx_pkg::AURX_OFS_DIV_HIGH, 8'h3C, 8'h3C, 1'b0},
		'{aurx_pkg::AURX_OFS_DIV_LOW, 8'h00, 8'h00, 1'b0}, '{BC, 8'h00, 8'h40, 1'b0},
		'{TS, 8'h04, 8'h06, 1'b0}, '{8'h20, 8'h5A, 8'h00, 1'b1}};
	logic clock;
	logic sys_rst;
	logic sleep_mode;
	aurx_pkg::aurx_apb_req_t req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic serial_in_line;
	logic serial_out_line;
	logic receive_irq;
	logic wake_request;
	logic [31:0] rdata;
	logic rerr;
	logic [12:0] cap;
	int num_errors = 0;
	int samples_checked = 0;
	aurx_top dut (.clock(clock), .sys_rst(sys_rst), .apb_req(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_in_line(serial_in_line),
		.sleep_mode(sleep_mode), .serial_out_line(serial_out_line),
		.receive_irq(receive_irq), .wake_request(wake_request));
	aurx_node #(.BIT_CLOCKS(16)) node (.clock(clock), .serial_out_line(serial_out_line),
		.serial_in_line(serial_in_line));
	initial clock = 1'b0;
	always #2.5 clock = ~clock;
	// ====
	// Tasks
	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		samples_checked++;
		if ((got & m) !== (exp & m)) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
		int n;
		@(posedge clock);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: {24'h0, d}};
		@(posedge clock);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		rerr = pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			$display("[FAIL] %0t bus timeout", $time);
			final_report();
		end
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		apb(a, 1'b0, 8'h00);
		chk(rdata, {24'h0, e}, {24'hFF_FFFF, m});
	endtask : rdc
	task automatic wait_hi(input logic sel);
		int n;
		n = 0;
		while ((sel ? wake_request : receive_irq) !== 1'b1 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, n < 2000}, 32'h1, 32'h1);
		if (n >= 2000) begin
			final_report();
		end
	endtask : wait_hi
	// ====
	// Sequence
	initial begin
		req = '0;
		sleep_mode = 1'b0;
		sys_rst = 1'b1;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		rdc(ST, aurx_pkg::AURX_RST_REG, 8'hFF);
		rdc(TS, aurx_pkg::AURX_RST_TX_STATUS, 8'hFF);
		rdc(BC, aurx_pkg::AURX_RST_BAUD_CTRL, 8'hFF);
		foreach (ROWS[i]) begin
			apb(ROWS[i].addr, 1'b1, ROWS[i].wdata);
			chk({31'h0, rerr}, {31'h0, ROWS[i].err}, 32'h1);
			rdc(ROWS[i].addr, ROWS[i].rdata, 8'hFF);
			chk({31'h0, rerr}, {31'h0, ROWS[i].err}, 32'h1);
		end
		$display("test registers done");
		apb(FL, 1'b1, 8'h08);
		apb(ST, 1'b1, 8'h90);
		node.send_char(9'h0A5, 8, 1'b1);
		wait_hi(1'b0);
		rdc(ST, 8'h90, 8'hFF);
		rdc(DT, 8'hA5, 8'hFF);
		rdc(FL, 8'h08, 8'h09);
		$display("test receive done");
		apb(ST, 1'b1, 8'hD8);
		node.send_char(9'h033, 9, 1'b1);
		rdc(FL, 8'h00, 8'h01);
		node.send_char(9'h181, 9, 1'b1);
		wait_hi(1'b0);
		rdc(ST, 8'hD9, 8'hFF);
		rdc(DT, 8'h81, 8'hFF);
		apb(ST, 1'b1, 8'hD0);
		node.send_char(9'h033, 9, 1'b1);
		wait_hi(1'b0);
		rdc(DT, 8'h33, 8'hFF);
		$display("test address detect done");
		apb(ST, 1'b1, 8'h90);
		node.send_char(9'h011, 8, 1'b0);
		wait_hi(1'b0);
		rdc(ST, 8'h04, 8'h04);
		rdc(DT, 8'h11, 8'hFF);
		node.send_char(9'h022, 8, 1'b1);
		node.send_char(9'h044, 8, 1'b1);
		rdc(ST, 8'h02, 8'h02);
		rdc(DT, 8'h22, 8'hFF);
		apb(ST, 1'b1, 8'h80);
		rdc(ST, 8'h80, 8'hFF);
		node.send_char(9'h077, 8, 1'b1);
		rdc(FL, 8'h00, 8'h01);
		$display("test errors done");
		apb(ST, 1'b1, 8'h90);
		apb(BC, 1'b1, 8'h02);
		rdc(BC, 8'h42, 8'hFF);
		sleep_mode <= 1'b1;
		node.set_line(1'b0);
		wait_hi(1'b1);
		repeat (40) @(posedge clock);
		chk({31'h0, wake_request}, 32'h1, 32'h1);
		sleep_mode <= 1'b0;
		rdc(FL, 8'h01, 8'h01);
		rdc(BC, 8'h02, 8'h02);
		repeat (120) @(posedge clock);
		node.set_line(1'b1);
		repeat (10) @(posedge clock);
		rdc(BC, 8'h00, 8'h02);
		rdc(DT, 8'h00, 8'h00);
		rdc(FL, 8'h00, 8'h01);
		node.send_char(9'h05A, 8, 1'b1);
		wait_hi(1'b0);
		rdc(DT, 8'h5A, 8'hFF);
		$display("test wake done");
		// A break of 13 bits at 144 clocks looks like 9 bits at 208 clocks to the receiver.
		apb(aurx_pkg::AURX_OFS_DIV_LOW, 1'b1, 8'h0C);
		node.set_line(1'b0);
		repeat (1872) @(posedge clock);
		node.set_line(1'b1);
		wait_hi(1'b0);
		rdc(ST, 8'h00, 8'h04);
		rdc(DT, 8'h00, 8'hFF);
		apb(aurx_pkg::AURX_OFS_DIV_LOW, 1'b1, 8'h00);
		$display("test slow break done");
		fork
			begin
				node.capture(cap);
				chk({19'h0, cap}, 32'h1000, 32'h1FFF);
				node.capture(cap);
				chk({19'h0, cap}, 32'h1F55, 32'h1FFF);
			end
			begin
				apb(TS, 1'b1, 8'h2C);
				apb(TB, 1'b1, 8'hFF);
				apb(TB, 1'b1, 8'h55);
				repeat (20) @(posedge clock);
				rdc(TS, 8'h28, 8'h2A);
			end
		join
		rdc(TS, 8'h26, 8'h2E);
		rdc(FL, 8'h02, 8'h02);
		$display("test break done");
		final_report();
	end
endmodule : aurx_tb
